// [dmaack_ctrl.sv]
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Address mode and acknowledge control of a two-channel transfer unit.
// ****************************************************************
module dmaack_ctrl
  import dmaack_pkg::*;
#(
  parameter int P_DATA_W = DATA_W,
  parameter int P_N_SUB = N_SUB
)
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST,
  // Register port.
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [P_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [P_DATA_W-1:0] RDATA,
  // Selected internal interrupt sources.
  input wire logic [P_N_SUB-1:0] SRC_REQ,
  output logic [P_N_SUB-1:0] SRC_CLR,
  output logic [P_N_SUB-1:0] IRQ_FWD,
  // Transfer engine.
  input wire logic [P_N_SUB-1:0] XFER_DONE,
  output logic [P_N_SUB-1:0] XFER_START,
  output logic [1:0] WIDE_ADDR,
  // Interrupt.
  output logic IRQ
);

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  if (P_DATA_W != DATA_W)
  begin : g_chk_data_w
    $error("dmaack_ctrl needs a 16-bit data port");
  end

  if (P_N_SUB != N_SUB)
  begin : g_chk_n_sub
    $error("dmaack_ctrl serves exactly four sub-channels");
  end

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    dmaack_mode_ack_s mode;
    logic [3:0] te;
    logic [1:0] me;
    logic [3:0] mask;
    logic [P_DATA_W-1:0] rdata;
    logic [1:0] wide;
  } dmaack_ctrl_st_s;

  dmaack_ctrl_st_s s_r;
  dmaack_ctrl_st_s s_nxt;

  logic [3:0] stat;
  logic [3:0] done_evt;
  logic rd_stat;
  logic irq_i;
  dmaack_chan_cfg_s cfg [P_N_SUB];

  // ****************************************************************
  // Sub-channel configuration decode.
  // ****************************************************************
  // In full mode A carries the channel and B is idle with its source
  // passed straight through; in short mode A and B stand alone.
  function automatic dmaack_chan_cfg_s sub_cfg(
    input logic wide,
    input logic is_b,
    input logic te_own,
    input logic te_a,
    input logic me,
    input logic ack
  );
    dmaack_chan_cfg_s c;
    c = '0;
    if (wide) // [RULE1] [RULE2]
    begin
      c.accept = !is_b && te_a && me; // [RULE13]
      c.gate_en = !is_b && te_a;
      c.auto_clr = ack;
    end
    else
    begin
      c.accept = te_own; // [RULE14]
      c.gate_en = te_own;
      c.auto_clr = ack;
    end
    return c;
  endfunction : sub_cfg

  always_comb
  begin
    cfg[SUB_0A] = sub_cfg(s_r.mode.ch0_wide_addr_sel, 1'b0, s_r.te[SUB_0A], s_r.te[SUB_0A],
                          s_r.me[0], s_r.mode.ch0_irq_source_auto_clear); // [RULE12]
    cfg[SUB_0B] = sub_cfg(s_r.mode.ch0_wide_addr_sel, 1'b1, s_r.te[SUB_0B], s_r.te[SUB_0A],
                          s_r.me[0], s_r.mode.ch0_irq_source_auto_clear);
    cfg[SUB_1A] = sub_cfg(s_r.mode.ch1_wide_addr_sel, 1'b0, s_r.te[SUB_1A], s_r.te[SUB_1A],
                          s_r.me[1], s_r.mode.ch1_irq_source_auto_clear); // [RULE12]
    cfg[SUB_1B] = sub_cfg(s_r.mode.ch1_wide_addr_sel, 1'b1, s_r.te[SUB_1B], s_r.te[SUB_1A],
                          s_r.me[1], s_r.mode.ch1_irq_source_auto_clear);
  end

  // ****************************************************************
  // Sub-channels.
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < P_N_SUB; gi++)
    begin : g_sub
      dmaack_chan u_chan (
        .clk(CLK_SYS),
        .rst(RST),
        .cfg(cfg[gi]),
        .src_req(SRC_REQ[gi]),
        .xfer_done(XFER_DONE[gi]),
        .xfer_start(XFER_START[gi]),
        .src_clr(SRC_CLR[gi]),
        .irq_fwd(IRQ_FWD[gi]),
        .done_evt(done_evt[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Interrupt status.
  // ****************************************************************
  assign rd_stat = RD && (ADDR == REG_IRQ_STAT);

  dmaack_irq #(
    .N(4)
  ) u_irq (
    .clk(CLK_SYS),
    .rst(RST),
    .evt(done_evt),
    .rd_stat(rd_stat),
    .mask(s_r.mask),
    .stat(stat),
    .irq(irq_i)
  );

  // ****************************************************************
  // Register port.
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    if (WR)
    begin
      if (ADDR == REG_MODE_ACK)
      begin
        // Reserved bits are stored as written. [RULE3] [RULE4] [RULE5]
        s_nxt.mode = WDATA[MODE_ACK_LSB +: 8];
      end
      else if (ADDR == REG_ENABLE)
      begin
        s_nxt.te = WDATA[EN_TE_LSB +: 4];
        s_nxt.me = WDATA[EN_ME_LSB +: 2];
      end
      else if (ADDR == REG_IRQ_MASK)
      begin
        s_nxt.mask = WDATA[3:0];
      end
    end
    if (RD)
    begin
      if (ADDR == REG_MODE_ACK)
      begin
        s_nxt.rdata[MODE_ACK_LSB +: 8] = s_r.mode;
      end
      else if (ADDR == REG_ENABLE)
      begin
        s_nxt.rdata[EN_TE_LSB +: 4] = s_r.te;
        s_nxt.rdata[EN_ME_LSB +: 2] = s_r.me;
      end
      else if (ADDR == REG_IRQ_STAT)
      begin
        s_nxt.rdata[3:0] = stat;
      end
      else if (ADDR == REG_IRQ_MASK)
      begin
        s_nxt.rdata[3:0] = s_r.mask;
      end
    end
    s_nxt.wide = {s_nxt.mode.ch1_wide_addr_sel, s_nxt.mode.ch0_wide_addr_sel}; // [RULE1] [RULE2]
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      s_r.mode <= MODE_ACK_RESET; // [RULE3] [RULE4]
      s_r.te <= TE_RESET;
      s_r.me <= ME_RESET;
      s_r.mask <= MASK_RESET;
      s_r.rdata <= '0;
      s_r.wide <= 2'h0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign RDATA = s_r.rdata;
  assign WIDE_ADDR = s_r.wide;
  assign IRQ = irq_i;

endmodule : dmaack_ctrl

`default_nettype wire

// [dmaack_pkg.sv]
// Function
// (RULE1) Channel 1 mode bit 15: 0 short address mode, 1 full mode joining 1A and 1B.
// (RULE2) Channel 0 mode bit 14: 0 short address mode, 1 full mode joining 0A and 0B.
// (RULE3) Reserved bits 13 and 12 reset to zero and are plain read/write storage.
// (RULE4) Reserved bits 10 and 8 reset to zero and are plain read/write storage.
// (RULE5) Software always writes zero into every reserved bit.
// (RULE6) Transfer enable and acknowledge set: each transfer clears the selected interrupt source.
// (RULE7) Transfer enable and acknowledge set: the source raises no CPU or peer request.
// (RULE8) Enable set, acknowledge clear: source stays set and may request concurrently.
// (RULE9) Enable set, acknowledge clear: CPU or peer transfer clears the source itself.
// (RULE10) Transfer enable clear: the source requests CPU or peer whatever acknowledge holds.
// (RULE11) Clearing and suppression ignore the channel master enable bit; the code in full mode clears only on a transfer, which needs it.
// (RULE12) Channel 0 acknowledge sits at bit 9, channel 1 acknowledge at bit 11.
// (RULE13) Full mode accepts source requests only with transfer and master enable both set.
// (RULE14) Short mode runs sub-channels A and B as two independent channels.

// ****************************************************************
// Package of shared constants and types.
// ****************************************************************
package dmaack_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int N_SUB = 4;

  // Register offsets.
  localparam logic [7:0] REG_MODE_ACK = 8'h00;
  localparam logic [7:0] REG_ENABLE = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

  // Mode and acknowledge byte sits at data bits 15 to 8.
  localparam int MODE_ACK_LSB = 8;
  localparam logic [7:0] MODE_ACK_RESET = 8'h00;

  // Enable register fields.
  localparam int EN_TE_LSB = 0;
  localparam int EN_ME_LSB = 4;
  localparam logic [3:0] TE_RESET = 4'h0;
  localparam logic [1:0] ME_RESET = 2'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // Sub-channel indices.
  localparam int SUB_0A = 0;
  localparam int SUB_0B = 1;
  localparam int SUB_1A = 2;
  localparam int SUB_1B = 3;

  typedef struct packed {
    logic ch1_wide_addr_sel;
    logic ch0_wide_addr_sel;
    logic rsvd13;
    logic rsvd12;
    logic ch1_irq_source_auto_clear;
    logic rsvd10;
    logic ch0_irq_source_auto_clear;
    logic rsvd8;
  } dmaack_mode_ack_s;

  typedef struct packed {
    logic accept;
    logic gate_en;
    logic auto_clr;
  } dmaack_chan_cfg_s;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_BUSY = 2'b10
  } dmaack_chan_state_e;

endpackage : dmaack_pkg

// [dmaack_irq.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Sticky event status with read clear and masked level output.
// ****************************************************************
module dmaack_irq
  import dmaack_pkg::*;
#(
  parameter int N = 4
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Events and software access.
  input wire logic [N-1:0] evt,
  input wire logic rd_stat,
  input wire logic [N-1:0] mask,
  // Status and interrupt.
  output logic [N-1:0] stat,
  output logic irq
);

  typedef struct packed {
    logic [N-1:0] stat;
    logic irq;
  } dmaack_irq_st_s;

  dmaack_irq_st_s s_r;
  dmaack_irq_st_s s_nxt;

  if (N < 1)
  begin : g_chk_n
    $error("dmaack_irq needs at least one event");
  end

  always_comb
  begin
    s_nxt = s_r;
    // A read clears, but an event in the same cycle is kept.
    s_nxt.stat = (rd_stat ? {N{1'b0}} : s_r.stat) | evt;
    s_nxt.irq = |(s_nxt.stat & mask);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign stat = s_r.stat;
  assign irq = s_r.irq;

endmodule : dmaack_irq

`default_nettype wire

// [dmaack_chan.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// One sub-channel: request acceptance, source clear and forwarding.
// ****************************************************************
module dmaack_chan
  import dmaack_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Configuration.
  input wire dmaack_chan_cfg_s cfg,
  // Interrupt source and transfer engine.
  input wire logic src_req,
  input wire logic xfer_done,
  // Results.
  output logic xfer_start,
  output logic src_clr,
  output logic irq_fwd,
  output logic done_evt
);

  typedef struct packed {
    dmaack_chan_state_e state;
    logic start;
    logic clr;
    logic fwd;
    logic done;
  } dmaack_chan_st_s;

  dmaack_chan_st_s s_r;
  dmaack_chan_st_s s_nxt;
  logic suppress;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.clr = 1'b0;
    s_nxt.done = 1'b0;
    // Suppression uses the transfer enable and acknowledge, not the master enable. [RULE7] [RULE8] [RULE10] [RULE11]
    suppress = cfg.gate_en & cfg.auto_clr;
    // While suppress is set the source is not forwarded; otherwise it is forwarded one cycle later.
    s_nxt.fwd = src_req & ~suppress; // [RULE7] [RULE8] [RULE10]
    case (s_r.state)
      CH_IDLE:
      begin
        if (cfg.accept && src_req && !s_r.clr) // [RULE13] [RULE14]
        begin
          s_nxt.start = 1'b1;
          s_nxt.clr = suppress; // [RULE6] [RULE9]
          s_nxt.state = CH_BUSY;
        end
      end
      CH_BUSY:
      begin
        if (xfer_done)
        begin
          s_nxt.done = 1'b1;
          s_nxt.state = CH_IDLE;
        end
      end
      default:
      begin
        s_nxt.state = CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '{state: CH_IDLE, start: 1'b0, clr: 1'b0, fwd: 1'b0, done: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign xfer_start = s_r.start;
  assign src_clr = s_r.clr;
  assign irq_fwd = s_r.fwd;
  assign done_evt = s_r.done;

endmodule : dmaack_chan

`default_nettype wire

// [dmaack_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checker.
// ********
module dmaack_ctrl_props
  import dmaack_pkg::*;
#(
  parameter int P_DATA_W = DATA_W,
  parameter int P_N_SUB = N_SUB
)
(
  // Clock.
  input wire logic CLK_SYS,
  input wire logic RST,
  // Registers.
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [P_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [P_DATA_W-1:0] RDATA,
  // Sources.
  input wire logic [P_N_SUB-1:0] SRC_REQ,
  input wire logic [P_N_SUB-1:0] SRC_CLR,
  input wire logic [P_N_SUB-1:0] IRQ_FWD,
  input wire logic [P_N_SUB-1:0] XFER_DONE,
  input wire logic [P_N_SUB-1:0] XFER_START,
  input wire logic [1:0] WIDE_ADDR,
  input wire logic IRQ
);
  dmaack_mode_ack_s m_r;
  logic [5:0] en_r;
  logic [3:0] sup;
  logic [3:0] acc;
  logic w0, w1, a0, a1;
  always_ff @(posedge CLK_SYS)
    if (RST)
      m_r <= MODE_ACK_RESET;
    else if (WR && ADDR == REG_MODE_ACK)
      m_r <= WDATA[15:8];
  always_ff @(posedge CLK_SYS)
    if (RST)
      en_r <= 6'h00;
    else if (WR && ADDR == REG_ENABLE)
      en_r <= WDATA[5:0];
  assign w0 = m_r.ch0_wide_addr_sel;
  assign w1 = m_r.ch1_wide_addr_sel;
  assign a0 = m_r.ch0_irq_source_auto_clear;
  assign a1 = m_r.ch1_irq_source_auto_clear;
  // In full mode sub-channel B never suppresses; its source is passed straight through.
  assign sup = {(w1 ? 1'b0 : en_r[3]) & a1, en_r[2] & a1,
                (w0 ? 1'b0 : en_r[1]) & a0, en_r[0] & a0};
  assign acc = {en_r[3] & !w1, en_r[2] & (!w1 | en_r[5]),
                en_r[1] & !w0, en_r[0] & (!w0 | en_r[4])};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence rd_mode;
    RD && ADDR == REG_MODE_ACK;
  endsequence
  ch1_wide_a: assert property (
    WIDE_ADDR[1] == w1) else $error("ch1 mode");
  ch0_wide_a: assert property (
    WIDE_ADDR[0] == w0) else $error("ch0 mode");
  fwd_gate_a: assert property (
    !$past(RST) |-> IRQ_FWD == $past(SRC_REQ & ~sup)) else $error("forward");
  auto_clr_a: assert property (
    !$past(RST) |-> SRC_CLR == (XFER_START & $past(sup))) else $error("clear");
  start_gate_a: assert property (
    (XFER_START & ~$past(acc & SRC_REQ)) == 4'h0) else $error("start");
  start_pulse_a: assert property (
    (XFER_START & $past(XFER_START)) == 4'h0) else $error("pulse");
  rd_mode_a: assert property (
    rd_mode |=> RDATA == {$past(m_r), 8'h00}) else $error("mode read");
  rd_idle_a: assert property (
    !RD |=> RDATA == 16'h0000) else $error("idle read");
endmodule : dmaack_ctrl_props

bind dmaack_ctrl dmaack_ctrl_props #(.P_DATA_W(P_DATA_W), .P_N_SUB(P_N_SUB)) u_props (
  .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .SRC_REQ(SRC_REQ), .SRC_CLR(SRC_CLR), .IRQ_FWD(IRQ_FWD),
  .XFER_DONE(XFER_DONE), .XFER_START(XFER_START), .WIDE_ADDR(WIDE_ADDR), .IRQ(IRQ));
`default_nettype wire

// [dmaack_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ********
// Interrupt sources and transfer engine.
// ********
module dmaack_src_model
  import dmaack_pkg::*;
(
  // Clock.
  input wire logic clk,
  input wire logic rst,
  // Bench side.
  input wire logic [3:0] set,
  input wire logic [3:0] sw_clr,
  input wire logic slow,
  // Block side.
  input wire logic [3:0] src_clr,
  input wire logic [3:0] xfer_start,
  output logic [3:0] src_req,
  output logic [3:0] xfer_done
);
  logic [19:0] sh_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      src_req <= 4'h0;
      sh_r <= 20'h0_0000;
    end
    else
    begin
      // A request holds until the block or software clears it.
      src_req <= (src_req & ~src_clr & ~sw_clr) | set;
      sh_r <= {sh_r[15:0], xfer_start};
    end
  end
  assign xfer_done = slow ? sh_r[19:16] : sh_r[3:0];
endmodule : dmaack_src_model
`default_nettype wire

// [dmaack_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ********
// Testbench.
// ********
module dmaack_ctrl_tb
  import dmaack_pkg::*;
;
  logic CLK_SYS, RST, WR, RD, IRQ, slow;
  logic [7:0] ADDR;
  logic [15:0] WDATA, RDATA;
  logic [3:0] SRC_REQ, SRC_CLR, IRQ_FWD, XFER_DONE, XFER_START;
  logic [3:0] set, sw_clr, cs, fs, ss;
  logic [1:0] WIDE_ADDR;
  int errors, compares;
  dmaack_ctrl u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SRC_REQ(SRC_REQ), .SRC_CLR(SRC_CLR), .IRQ_FWD(IRQ_FWD),
    .XFER_DONE(XFER_DONE), .XFER_START(XFER_START), .WIDE_ADDR(WIDE_ADDR), .IRQ(IRQ));
  dmaack_src_model u_src (.clk(CLK_SYS), .rst(RST), .set(set), .sw_clr(sw_clr),
    .slow(slow), .src_clr(SRC_CLR), .xfer_start(XFER_START), .src_req(SRC_REQ),
    .xfer_done(XFER_DONE));
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic chk_v(input logic [3:0] g, input logic [3:0] e, input string m);
    chk({12'h000, g}, {12'h000, e}, m);
  endtask : chk_v
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string m);
    @(posedge CLK_SYS);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    chk(RDATA, e, m);
  endtask : rd
  task automatic src(input logic [3:0] s, input logic [3:0] c);
    @(posedge CLK_SYS);
    set <= s;
    sw_clr <= c;
    @(posedge CLK_SYS);
    set <= 4'h0;
    sw_clr <= 4'h0;
  endtask : src
  task automatic run(input int n);
    cs = 4'h0;
    fs = 4'h0;
    ss = 4'h0;
    repeat (n)
    begin
      @(posedge CLK_SYS);
      #1;
      cs |= SRC_CLR;
      fs |= IRQ_FWD;
      ss |= XFER_START;
    end
  endtask : run
  task automatic t_reset;
    rd(REG_MODE_ACK, 16'h0000, "mode");
    rd(REG_ENABLE, 16'h0000, "enable");
    rd(8'h10, 16'h0000, "unmapped");
    $display("reset test done");
  endtask : t_reset
  task automatic t_mode;
    for (int k = 0; k < 4; k++)
    begin
      wr(REG_MODE_ACK, {k[1:0], 14'h0000});
      rd(REG_MODE_ACK, {k[1:0], 14'h0000}, "mode");
      chk_v({2'b00, WIDE_ADDR}, {2'b00, k[1:0]}, "wide");
    end
    wr(REG_MODE_ACK, 16'h0A00);
    rd(REG_MODE_ACK, 16'h0A00, "ack");
    $display("mode test done");
  endtask : t_mode
  task automatic t_ack;
    wr(REG_MODE_ACK, 16'h0200);
    wr(REG_ENABLE, 16'h000F);
    src(4'hF, 4'h0);
    run(12);
    chk_v(cs, 4'h3, "clear");
    chk_v(fs, 4'hC, "forward");
    chk_v(ss, 4'hF, "start");
    wr(REG_ENABLE, 16'h0000);
    src(4'h0, 4'hF);
    run(8);
    chk_v({3'b000, IRQ}, 4'h0, "irq off");
    wr(REG_IRQ_MASK, 16'h000F);
    run(2);
    chk_v({3'b000, IRQ}, 4'h1, "irq on");
    rd(REG_IRQ_STAT, 16'h000F, "status");
    run(2);
    chk_v({3'b000, IRQ}, 4'h0, "irq clear");
    wr(REG_IRQ_MASK, 16'h0000);
    $display("ack test done");
  endtask : t_ack
  task automatic t_off;
    wr(REG_MODE_ACK, 16'h0A00);
    src(4'hF, 4'h0);
    run(6);
    chk_v(fs, 4'hF, "forward");
    chk_v(cs | ss, 4'h0, "idle");
    src(4'h0, 4'hF);
    $display("off test done");
  endtask : t_off
  task automatic t_full;
    wr(REG_MODE_ACK, 16'hCA00);
    wr(REG_ENABLE, 16'h0005);
    src(4'hF, 4'h0);
    run(8);
    chk_v(ss | cs, 4'h0, "no master");
    chk_v(fs, 4'hA, "forward");
    slow <= 1'b1;
    wr(REG_ENABLE, 16'h0035);
    run(16);
    chk_v(ss, 4'h5, "start");
    chk_v(cs, 4'h5, "clear");
    chk_v(fs, 4'hA, "forward");
    wr(REG_ENABLE, 16'h0000);
    wr(REG_MODE_ACK, 16'h0000);
    src(4'h0, 4'hF);
    slow <= 1'b0;
    $display("full test done");
  endtask : t_full
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  initial
  begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  initial
  begin
    RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 16'h0000;
    set = 4'h0;
    sw_clr = 4'h0;
    slow = 1'b0;
    errors = 0;
    compares = 0;
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_reset;
    t_mode;
    t_ack;
    t_off;
    t_full;
    stop_test;
  end
  initial
  begin
    repeat (3000) @(posedge CLK_SYS);
    errors++;
    stop_test;
  end
endmodule : dmaack_ctrl_tb
`default_nettype wire
